// file: pmmir_regs.vh
// Register indices, field positions, reset values and mode codes of the PHY mode/crossover/interrupt register bank.
`ifndef PMMIR_REGS_VH
`define PMMIR_REGS_VH
`define PMMIR_IDX_CTRL 5'h00
`define PMMIR_IDX_MODE_ADDR 5'h12
`define PMMIR_IDX_XOVER 5'h1b
`define PMMIR_IDX_IRQ_FLAGS 5'h1d
`define PMMIR_IDX_IRQ_MASK 5'h1e
`define PMMIR_IDX_ANEG_STAT 5'h1f
`define PMMIR_MODE_RST 3'h7
`define PMMIR_ADDR_RST 5'h01
`define PMMIR_MASK_RST 8'h00
`define PMMIR_ST31_FILL_RST 7'h02
`define PMMIR_SPEED_RST 3'h0
`define PMMIR_MODE_10HD 3'h0
`define PMMIR_MODE_10FD 3'h1
`define PMMIR_MODE_100HD 3'h2
`define PMMIR_MODE_100FD 3'h3
`define PMMIR_MODE_AN100HD 3'h4
`define PMMIR_MODE_REPEATER 3'h5
`define PMMIR_MODE_RSVD 3'h6
`define PMMIR_MODE_ALL 3'h7
`define PMMIR_BIT_SOFT_RST 15
`define PMMIR_BIT_SPEED 13
`define PMMIR_BIT_ANEG_EN 12
`define PMMIR_BIT_DUPLEX 8
`define PMMIR_BIT_LOOPBACK 14
`define PMMIR_BIT_PWR_DOWN 11
`define PMMIR_BIT_COL_TEST 7
`define PMMIR_BIT_XOVR_OVR 15
`define PMMIR_BIT_XOVR_AUTO 14
`define PMMIR_BIT_XOVR_SWAP 13
`define PMMIR_BIT_PLL_LOCK 10
`define PMMIR_BIT_POLARITY 4
`define PMMIR_BIT_ANEG_DONE 12
`endif

// file: pmmir_sync.v
// Two-flop synchroniser for a bundle of level signals from outside the clock domain.
`timescale 1ns/1ps
module pmmir_sync #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Data
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      meta_q <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // pmmir_sync

// file: pmmir_mode_dec.v
// Decodes the operating-mode code into control defaults, advertisement and carrier-sense behaviour.
`timescale 1ns/1ps
`include "pmmir_regs.vh"
module pmmir_mode_dec (
  // Mode code
  input wire [2:0] mode,
  // Decoded defaults
  output reg [2:0] ctrl_bits,
  output reg [3:0] adv_bits,
  output reg crs_on_tx
);
  // Control bits are {speed, aneg enable, duplex}; advertisement is bits 8:5.
  always @* begin
    ctrl_bits = 3'h6;
    adv_bits = 4'hf;
    crs_on_tx = 1'b1;
    case (mode)
      `PMMIR_MODE_10HD: begin
        ctrl_bits = 3'h0;
        adv_bits = 4'h0;
        crs_on_tx = 1'b1;
      end
      `PMMIR_MODE_10FD: begin
        ctrl_bits = 3'h1;
        adv_bits = 4'h0;
        crs_on_tx = 1'b0;
      end
      `PMMIR_MODE_100HD: begin
        ctrl_bits = 3'h4;
        adv_bits = 4'h0;
        crs_on_tx = 1'b1;
      end
      `PMMIR_MODE_100FD: begin
        ctrl_bits = 3'h5;
        adv_bits = 4'h0;
        crs_on_tx = 1'b0;
      end
      `PMMIR_MODE_AN100HD: begin
        ctrl_bits = 3'h6;
        adv_bits = 4'h4;
        crs_on_tx = 1'b1;
      end
      `PMMIR_MODE_REPEATER: begin
        ctrl_bits = 3'h6;
        adv_bits = 4'h4;
        crs_on_tx = 1'b0;
      end
      `PMMIR_MODE_ALL: begin
        ctrl_bits = 3'h6;
        adv_bits = 4'hf;
        crs_on_tx = 1'b1;
      end
      default: begin
        ctrl_bits = 3'h6;
        adv_bits = 4'hf;
        crs_on_tx = 1'b1;
      end
    endcase
  end
endmodule // pmmir_mode_dec

// file: pmmir_top.v
// PHY management register bank: operating mode, crossover control, interrupt flags and negotiation status.
//
// Function
// - Three-bit mode field at bits 7:5 of index 18, reset 111b, soft-reset immune.
// - Five-bit management address at bits 4:0, reset 00001b, kept; accesses match it.
// - Modes 000b/001b give fixed 10M half/full, negotiation off.
// - Modes 010b/011b give fixed 100M half/full; carrier sense on tx only in half.
// - Mode 100b negotiates advertising only 100M half, carrier sense on tx and rx.
// - Mode 101b is repeater: negotiation, 100M half advertised, carrier sense rx only.
// - Mode 111b negotiates advertising all four 10/100 abilities.
// - Index 27 bit 15 picks strap or register bits 14:13 for crossover.
// - Under override bit 14 enables automatic crossover, else bit 13 fixes it.
// - Manual bit 13 clear keeps pairs straight, set swaps them.
// - Bit 10 holds the 10M receive PLL on reference; soft-reset immune.
// - Read-only bit 4 reports detected 10BASE-T receive polarity, reset zero.
// - Index 29 flags latch high on the seven listed events.
// - Index 30 bits 7:1 enable interrupt sources (bit 0 gates nothing), all masked at reset.
// - Index 31 bit 12 reads one once negotiation has finished while control bit 12 is set.
// - Index 31 bits 4:2 report resolved speed and duplex, reset 000b.
// - Control bit 13 speed, bit 8 duplex, bit 12 negotiation overriding both.
// - Immune fields survive only the control soft reset; hard reset initialises them.
`timescale 1ns/1ps
`include "pmmir_regs.vh"
module pmmir_top (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Management register access from the MAC
  input wire mgmt_req,
  input wire mgmt_wr,
  input wire [4:0] mgmt_phy_addr,
  input wire [4:0] mgmt_reg_idx,
  input wire [15:0] mgmt_wdata,
  output reg [15:0] mgmt_rdata,
  output reg mgmt_ack,
  // Configuration strap and PHY core status pins
  input wire crossover_auto_strap,
  input wire reversed_polarity_flag,
  input wire energy_present,
  input wire aneg_done_in,
  input wire remote_fault_in,
  input wire link_up_in,
  input wire partner_ack_in,
  input wire parallel_detect_fault_in,
  input wire page_received_in,
  input wire [2:0] resolved_speed_code,
  // Controls to the PHY core
  output reg [15:0] ctrl_reg,
  output reg [3:0] adv_abilities,
  output reg crs_on_tx,
  output reg crossover_auto_en,
  output reg crossover_swap,
  output reg rx_pll_ref_lock,
  output reg soft_reset_pulse,
  output reg irq_out
);
  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Synchronised pin inputs.
  // Every pin crosses two flops before any logic reads it, so status lags its pin by two cycles.
  wire [11:0] pin_sync;
  wire strap_s;
  wire pol_s;
  wire energy_s;
  wire aneg_s;
  wire rfault_s;
  wire link_s;
  wire pack_s;
  wire pdf_s;
  wire page_s;
  wire [2:0] speed_s;

  pmmir_sync #(
    .W(12)
  ) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .async_i({crossover_auto_strap, reversed_polarity_flag, energy_present, aneg_done_in, remote_fault_in,
              link_up_in, partner_ack_in, parallel_detect_fault_in, page_received_in, resolved_speed_code}),
    .sync_o(pin_sync)
  );

  assign strap_s = pin_sync[11];
  assign pol_s = pin_sync[10];
  assign energy_s = pin_sync[9];
  assign aneg_s = pin_sync[8];
  assign rfault_s = pin_sync[7];
  assign link_s = pin_sync[6];
  assign pack_s = pin_sync[5];
  assign pdf_s = pin_sync[4];
  assign page_s = pin_sync[3];
  assign speed_s = pin_sync[2:0];

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register state.
  reg [2:0] mode_q;
  reg [4:0] addr_q;
  reg xovr_ovr_q;
  reg xovr_auto_q;
  reg xovr_swap_q;
  reg pll_lock_q;
  reg [7:1] flags_q;
  reg [7:0] mask_q;
  reg [6:0] fill_q;
  reg [7:1] prev_q;
  reg ctl_loop_q;
  reg ctl_pdown_q;
  reg ctl_coltest_q;
  reg ctl_speed_q;
  reg ctl_aneg_q;
  reg ctl_duplex_q;
  reg soft_q;
  reg first_q;

  wire [2:0] dec_ctrl;
  wire [3:0] dec_adv;
  wire dec_crs;

  pmmir_mode_dec u_dec (
    .mode(mode_q),
    .ctrl_bits(dec_ctrl),
    .adv_bits(dec_adv),
    .crs_on_tx(dec_crs)
  );

  // Access is for this PHY when the address field matches.
  // A write that moves the address is still answered at the old one; the new address is
  // matched from the following cycle on.
  wire hit = mgmt_req & (mgmt_phy_addr == addr_q);
  wire wr_hit = hit & mgmt_wr;
  wire rd_hit = hit & ~mgmt_wr;

  // Returns one when the access is a write to the given index.
  function wr_to;
    input [4:0] idx;
    input [4:0] want;
    input en;
    begin
      wr_to = en & (idx == want);
    end
  endfunction

  // Packs the control fields into the index-0 image shared by the read path and the core output.
  function [15:0] ctrl_image;
    input loop;
    input speed;
    input aneg;
    input pdown;
    input duplex;
    input coltest;
    begin
      ctrl_image = 16'h0000;
      ctrl_image[`PMMIR_BIT_LOOPBACK] = loop;
      ctrl_image[`PMMIR_BIT_SPEED] = speed;
      ctrl_image[`PMMIR_BIT_ANEG_EN] = aneg;
      ctrl_image[`PMMIR_BIT_PWR_DOWN] = pdown;
      ctrl_image[`PMMIR_BIT_DUPLEX] = duplex;
      ctrl_image[`PMMIR_BIT_COL_TEST] = coltest;
    end
  endfunction

  // Current image of the control register.
  wire [15:0] ctrl_img = ctrl_image(ctl_loop_q, ctl_speed_q, ctl_aneg_q, ctl_pdown_q,
                                    ctl_duplex_q, ctl_coltest_q);

  // The soft reset acts one cycle late so that the write requesting it is acknowledged
  // normally; the other bits of that write are dropped.
  wire wr_ctrl = wr_to(mgmt_reg_idx, `PMMIR_IDX_CTRL, wr_hit);
  wire soft_go = wr_ctrl & mgmt_wdata[`PMMIR_BIT_SOFT_RST];
  wire soft_rst = soft_q; // Soft reset acts one cycle after the write.

  // The synchroniser resets to zero while link up idles high, so the first cycle after any reset
  // only loads the edge baseline; otherwise a false link-down flag would follow every hard reset.
  // Rising-edge events: energy appears, negotiation completes, remote fault, link lost, ack, fault, page.
  wire [7:1] ev_now = {energy_s, aneg_s, rfault_s, ~link_s, pack_s, pdf_s, page_s};
  wire [7:1] events = ev_now & ~prev_q & {7{~first_q}};
  wire rd_flags = rd_hit & (mgmt_reg_idx == `PMMIR_IDX_IRQ_FLAGS);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Soft-reset-immune fields: only hard reset initialises them.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      mode_q <= `PMMIR_MODE_RST;
      addr_q <= `PMMIR_ADDR_RST;
      pll_lock_q <= 1'b0;
    end else if (wr_to(mgmt_reg_idx, `PMMIR_IDX_MODE_ADDR, wr_hit)) begin
      mode_q <= mgmt_wdata[7:5];
      addr_q <= mgmt_wdata[4:0];
    end else if (wr_to(mgmt_reg_idx, `PMMIR_IDX_XOVER, wr_hit)) begin
      pll_lock_q <= mgmt_wdata[`PMMIR_BIT_PLL_LOCK];
    end
  end

  // Ordinary writable fields, reset by hard and soft reset alike.
  always @(posedge clk_sys) begin
    if (!rstn || soft_rst) begin
      xovr_ovr_q <= 1'b0;
      xovr_auto_q <= 1'b0;
      xovr_swap_q <= 1'b0;
      mask_q <= `PMMIR_MASK_RST;
      fill_q <= `PMMIR_ST31_FILL_RST;
    end else if (wr_hit) begin
      if (mgmt_reg_idx == `PMMIR_IDX_XOVER) begin
        xovr_ovr_q <= mgmt_wdata[`PMMIR_BIT_XOVR_OVR];
        xovr_auto_q <= mgmt_wdata[`PMMIR_BIT_XOVR_AUTO];
        xovr_swap_q <= mgmt_wdata[`PMMIR_BIT_XOVR_SWAP];
      end
      if (mgmt_reg_idx == `PMMIR_IDX_IRQ_MASK) begin
        mask_q <= mgmt_wdata[7:0];
      end
      if (mgmt_reg_idx == `PMMIR_IDX_ANEG_STAT) begin
        fill_q <= mgmt_wdata[11:5];
      end
    end
  end

  // Control register: a reset loads the mode defaults so the mode code steers operation.
  always @(posedge clk_sys) begin
    if (!rstn || soft_rst) begin
      ctl_loop_q <= 1'b0;
      ctl_pdown_q <= 1'b0;
      ctl_coltest_q <= 1'b0;
      ctl_speed_q <= dec_ctrl[2];
      ctl_aneg_q <= dec_ctrl[1];
      ctl_duplex_q <= dec_ctrl[0];
    end else if (wr_ctrl && !soft_go) begin
      // A soft-reset write leaves these alone; the reset reloads them one cycle later.
      ctl_loop_q <= mgmt_wdata[`PMMIR_BIT_LOOPBACK];
      ctl_speed_q <= mgmt_wdata[`PMMIR_BIT_SPEED];
      ctl_aneg_q <= mgmt_wdata[`PMMIR_BIT_ANEG_EN];
      ctl_pdown_q <= mgmt_wdata[`PMMIR_BIT_PWR_DOWN];
      ctl_duplex_q <= mgmt_wdata[`PMMIR_BIT_DUPLEX];
      ctl_coltest_q <= mgmt_wdata[`PMMIR_BIT_COL_TEST];
    end
  end

  // Soft reset request, self-clearing after one cycle.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= soft_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Latched event flags; a new event wins over the clear-on-read.
  // A read in the cycle of a new event returns the old flags and keeps the new one, so no
  // event is lost between two reads.
  always @(posedge clk_sys) begin
    if (!rstn || soft_rst) begin
      flags_q <= 7'h00;
      prev_q <= 7'h00;
      first_q <= 1'b1;
    end else begin
      prev_q <= ev_now;
      first_q <= 1'b0;
      if (rd_flags) begin
        flags_q <= events;
      end else begin
        flags_q <= flags_q | events;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Read data assembly; reserved fields stay zero.
  reg [15:0] rd_d;
  always @* begin
    rd_d = 16'h0000;
    case (mgmt_reg_idx)
      `PMMIR_IDX_CTRL: begin
        rd_d = ctrl_img;
      end
      `PMMIR_IDX_MODE_ADDR: begin
        rd_d = {8'h00, mode_q, addr_q};
      end
      `PMMIR_IDX_XOVER: begin
        rd_d[`PMMIR_BIT_XOVR_OVR] = xovr_ovr_q;
        rd_d[`PMMIR_BIT_XOVR_AUTO] = xovr_auto_q;
        rd_d[`PMMIR_BIT_XOVR_SWAP] = xovr_swap_q;
        rd_d[`PMMIR_BIT_PLL_LOCK] = pll_lock_q;
        rd_d[`PMMIR_BIT_POLARITY] = pol_s;
      end
      `PMMIR_IDX_IRQ_FLAGS: begin
        rd_d = {8'h00, flags_q, 1'b0};
      end
      `PMMIR_IDX_IRQ_MASK: begin
        rd_d = {8'h00, mask_q};
      end
      `PMMIR_IDX_ANEG_STAT: begin
        rd_d[`PMMIR_BIT_ANEG_DONE] = aneg_s & ctl_aneg_q;
        rd_d[11:5] = fill_q;
        rd_d[4:2] = speed_s;
      end
      default: begin
        rd_d = 16'h0000;
      end
    endcase
  end

  // Answer one cycle after a matching request.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      mgmt_ack <= 1'b0;
      mgmt_rdata <= 16'h0000;
    end else begin
      mgmt_ack <= hit;
      mgmt_rdata <= rd_hit ? rd_d : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Registered controls to the PHY core.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_reg <= 16'h0000;
      adv_abilities <= 4'h0;
      crs_on_tx <= 1'b1;
      crossover_auto_en <= 1'b0;
      crossover_swap <= 1'b0;
      rx_pll_ref_lock <= 1'b0;
      soft_reset_pulse <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_img;
      adv_abilities <= dec_adv;
      crs_on_tx <= dec_crs;
      // The strap rules crossover unless software has taken control of it.
      crossover_auto_en <= xovr_ovr_q ? xovr_auto_q : strap_s;
      crossover_swap <= xovr_ovr_q & ~xovr_auto_q & xovr_swap_q;
      rx_pll_ref_lock <= pll_lock_q;
      soft_reset_pulse <= soft_q;
      irq_out <= |({flags_q, 1'b0} & mask_q);
    end
  end
endmodule // pmmir_top

// file: pmmir_chk_sva.sv
// Port checker of the PHY mode, crossover and interrupt register bank.
`timescale 1ns/1ps
module pmmir_chk (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Management access
  input wire mgmt_req,
  input wire mgmt_wr,
  input wire [4:0] mgmt_reg_idx,
  input wire [15:0] mgmt_wdata,
  input wire [15:0] mgmt_rdata,
  input wire mgmt_ack,
  // Core controls
  input wire [3:0] adv_abilities,
  input wire crossover_auto_en,
  input wire crossover_swap,
  input wire rx_pll_ref_lock,
  input wire soft_reset_pulse
);
  // All checks use the system clock and rest during reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  ack_needs_req_a: assert property (mgmt_ack |-> $past(mgmt_req)) else $error("ack without request");
  rdata_empty_a: assert property (!mgmt_ack || $past(mgmt_wr) |-> mgmt_rdata == 16'h0000)
    else $error("rdata not empty");
  unmapped_zero_a: assert property (mgmt_ack && !($past(mgmt_reg_idx) inside {5'h00, 5'h12, 5'h1b,
    5'h1d, 5'h1e, 5'h1f}) |-> mgmt_rdata == 16'h0000) else $error("unmapped read not zero");
  status_fill_a: assert property (mgmt_ack && $past(mgmt_reg_idx) == 5'h1f |->
    mgmt_rdata[11:5] == 7'h02 || $past(mgmt_wr)) else $error("status fill wrong");
  swap_manual_a: assert property (crossover_swap |-> !crossover_auto_en) else $error("swap under auto");
  soft_pulse_a: assert property (mgmt_ack && $past(mgmt_wr) && $past(mgmt_reg_idx) == 5'h00 &&
    $past(mgmt_wdata[15]) |=> soft_reset_pulse) else $error("soft reset pulse missing");
  pll_follow_a: assert property (mgmt_ack && $past(mgmt_wr) && $past(mgmt_reg_idx) == 5'h1b
    |=> rx_pll_ref_lock == $past(mgmt_wdata[10], 2)) else $error("pll lock wrong");
  adv_all_a: assert property (mgmt_ack && $past(mgmt_wr) && $past(mgmt_reg_idx) == 5'h12 &&
    $past(mgmt_wdata[7:5]) == 3'h7 |=> adv_abilities == 4'hf) else $error("adv wrong");
  // Main scenarios.
  cover property (soft_reset_pulse);
  cover property (crossover_swap);
  cover property (mgmt_ack && !$past(mgmt_wr) && $past(mgmt_reg_idx) == 5'h1d);
endmodule // pmmir_chk
bind pmmir_top pmmir_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .mgmt_req(mgmt_req), .mgmt_wr(mgmt_wr),
  .mgmt_reg_idx(mgmt_reg_idx), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_ack(mgmt_ack),
  .adv_abilities(adv_abilities), .crossover_auto_en(crossover_auto_en), .crossover_swap(crossover_swap),
  .rx_pll_ref_lock(rx_pll_ref_lock), .soft_reset_pulse(soft_reset_pulse));

// file: pmmir_mac_model.sv
// Behavioural MAC issuing management register accesses.
`timescale 1ns/1ps
module pmmir_mac_model (
  // Clock
  input wire clk_sys,
  // Management access
  output reg mgmt_req,
  output reg mgmt_wr,
  output reg [4:0] mgmt_phy_addr,
  output reg [4:0] mgmt_reg_idx,
  output reg [15:0] mgmt_wdata
);
  // Idle bus at time zero.
  initial begin
    mgmt_req = 1'b0;
    mgmt_wr = 1'b0;
    mgmt_phy_addr = 5'h00;
    mgmt_reg_idx = 5'h00;
    mgmt_wdata = 16'h0000;
  end
  // One access by index; the released bus shows inverted values so nothing stale looks valid.
  task access(input w, input [4:0] a, input [4:0] i, input [15:0] d);
    begin
      @(posedge clk_sys);
      #10;
      mgmt_req = 1'b1;
      mgmt_wr = w;
      mgmt_phy_addr = a;
      mgmt_reg_idx = i;
      mgmt_wdata = d;
      @(posedge clk_sys);
      #10;
      mgmt_req = 1'b0;
      mgmt_wr = ~w;
      mgmt_phy_addr = ~a;
      mgmt_reg_idx = ~i;
      mgmt_wdata = ~d;
    end
  endtask
endmodule // pmmir_mac_model

// file: tb_phy_mode_mdix_irq_regs.sv
// Self-checking bench of the PHY mode, crossover and interrupt register bank.
`timescale 1ns/1ps
module tb_phy_mode_mdix_irq_regs;
  localparam [23:0] CT = {3'h6, 3'h6, 3'h6, 3'h6, 3'h5, 3'h4, 3'h1, 3'h0};
  localparam [11:0] SP = {3'h6, 3'h2, 3'h5, 3'h1};
  localparam [79:0] XD = {16'h0400, 16'hc000, 16'ha000, 16'h8000, 16'h0000};
  reg clk_sys = 1'b0;
  reg rstn = 1'b0;
  reg strap = 1'b0;
  reg pol = 1'b0;
  reg [7:1] ev = 7'h00;
  reg [2:0] spd = 3'h0;
  reg [31:0] rs = 32'h00016a67;
  reg [15:0] expq [$];
  reg [15:0] e;
  reg [7:0] msk;
  integer miscompares = 0;
  integer checked = 0;
  integer m;
  integer b;
  integer k;
  wire req, wr, ack, crs, auto, swap, pll, irq, spul;
  wire [4:0] pa, ri;
  wire [15:0] wd, rdata, ctrl;
  wire [3:0] adv;
  ////////////////////////////////////////////////////////////////////////
  // Clock at 100 ns.
  always #50 clk_sys = ~clk_sys;
  pmmir_mac_model mac (.clk_sys(clk_sys), .mgmt_req(req), .mgmt_wr(wr), .mgmt_phy_addr(pa), .mgmt_reg_idx(ri),
    .mgmt_wdata(wd));
  pmmir_top DUT (.clk_sys(clk_sys), .rstn(rstn), .mgmt_req(req), .mgmt_wr(wr), .mgmt_phy_addr(pa),
    .mgmt_reg_idx(ri), .mgmt_wdata(wd), .mgmt_rdata(rdata), .mgmt_ack(ack), .crossover_auto_strap(strap),
    .reversed_polarity_flag(pol), .energy_present(ev[7]), .aneg_done_in(ev[6]), .remote_fault_in(ev[5]),
    .link_up_in(~ev[4]), .partner_ack_in(ev[3]), .parallel_detect_fault_in(ev[2]), .page_received_in(ev[1]),
    .resolved_speed_code(spd), .ctrl_reg(ctrl), .adv_abilities(adv), .crs_on_tx(crs), .crossover_auto_en(auto),
    .crossover_swap(swap), .rx_pll_ref_lock(pll), .soft_reset_pulse(spul), .irq_out(irq));
  ////////////////////////////////////////////////////////////////////////
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task conclude;
    begin
      if (miscompares == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] x);
    begin
      checked = checked + 1;
      if (g !== x) begin
        miscompares = miscompares + 1;
        $display("BAD %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  // Notes the expected answer, if one is due, then runs the access.
  task acc(input w, input [4:0] a, input [4:0] i, input [15:0] d, input [15:0] x, input p);
    begin
      if (p)
        expq.push_back(x);
      mac.access(w, a, i, d);
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #10;
    end
  endtask
  // Each answer is matched with the oldest note; an answer with none due is a mismatch.
  // Answers are looked at mid-cycle, where they have settled.
  always @(negedge clk_sys) begin
    if (ack === 1'b1) begin
      if (expq.size() == 0)
        chk(16'h0001, 16'h0000);
      else
        chk(rdata, expq.pop_front());
    end
  end
  // Hang guard.
  initial begin
    #3000000;
    miscompares = miscompares + 1;
    conclude;
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rs = xs(rs);
    strap = rs[0];
    pol = rs[1];
    spd = SP[rs[3:2]*3 +: 3];
    repeat (20) @(posedge clk_sys);
    #10;
    rstn = 1'b1;
    cyc(3);
    acc(0, 5'h01, 5'h12, 16'h0000, 16'h00e1, 1);
    acc(0, 5'h01, 5'h1d, 16'h0000, 16'h0000, 1);
    acc(0, 5'h01, 5'h1e, 16'h0000, 16'h0000, 1);
    acc(0, 5'h01, 5'h1f, 16'h0000, {3'h0, 1'b0, 7'h02, spd, 2'h0}, 1);
    acc(1, 5'h01, 5'h07, 16'hffff, 16'h0000, 1);
    acc(0, 5'h01, 5'h07, 16'h0000, 16'h0000, 1);
    acc(0, 5'h02, 5'h12, 16'h0000, 16'h0000, 0);
    chk(ctrl, 16'h3000);
    acc(1, 5'h01, 5'h00, 16'h7fff, 16'h0000, 1);
    acc(0, 5'h01, 5'h00, 16'h0000, 16'h7980, 1);
    chk(ctrl, 16'h7980);
    for (m = 0; m < 8; m = m + 1) begin
      if (m != 6) begin
        acc(1, 5'h01, 5'h12, {8'h00, m[2:0], 5'h01}, 16'h0000, 1);
        cyc(2);
        if (m > 1)
          chk({15'h0000, crs}, {15'h0000, (m == 2 || m == 4 || m == 7)});
        if (m > 3)
          chk({12'h000, adv}, (m == 7) ? 16'h000f : 16'h0004);
        acc(1, 5'h01, 5'h00, 16'h8000, 16'h0000, 1);
        cyc(1);
        chk({15'h0000, spul}, 16'h0001);
        cyc(1);
        chk({15'h0000, spul}, 16'h0000);
        cyc(2);
        e = 16'h0000;
        e[13] = CT[m*3+2];
        e[12] = CT[m*3+1];
        e[8] = CT[m*3];
        chk(ctrl, e);
        acc(0, 5'h01, 5'h12, 16'h0000, {8'h00, m[2:0], 5'h01}, 1);
      end
    end
    for (k = 0; k < 5; k = k + 1) begin
      e = XD[k*16 +: 16];
      acc(1, 5'h01, 5'h1b, e, 16'h0000, 1);
      cyc(2);
      chk({15'h0000, auto}, {15'h0000, (e[15] ? e[14] : strap)});
      chk({15'h0000, swap}, {15'h0000, e[15] & ~e[14] & e[13]});
      chk({15'h0000, pll}, {15'h0000, e[10]});
      acc(0, 5'h01, 5'h1b, 16'h0000, (e & 16'he400) | {11'h000, pol, 4'h0}, 1);
    end
    acc(1, 5'h01, 5'h00, 16'h8000, 16'h0000, 1);
    cyc(4);
    acc(0, 5'h01, 5'h1b, 16'h0000, {11'h020, pol, 4'h0}, 1);
    rs = xs(rs);
    msk = rs[7:0] | 8'h10;
    acc(1, 5'h01, 5'h1e, {8'h00, msk}, 16'h0000, 1);
    acc(0, 5'h01, 5'h1e, 16'h0000, {8'h00, msk}, 1);
    for (b = 1; b < 8; b = b + 1) begin
      ev[b] = 1'b1;
      cyc(6);
      chk({15'h0000, irq}, {15'h0000, msk[b]});
      if (b == 6)
        acc(0, 5'h01, 5'h1f, 16'h0000, {3'h0, 1'b1, 7'h02, spd, 2'h0}, 1);
      acc(0, 5'h01, 5'h1d, 16'h0000, 16'h0001 << b, 1);
      ev[b] = 1'b0;
      cyc(6);
      chk({15'h0000, irq}, 16'h0000);
      acc(0, 5'h01, 5'h1d, 16'h0000, 16'h0000, 1);
    end
    acc(1, 5'h01, 5'h12, 16'h00e3, 16'h0000, 1);
    acc(0, 5'h01, 5'h12, 16'h0000, 16'h0000, 0);
    acc(0, 5'h03, 5'h12, 16'h0000, 16'h00e3, 1);
    rstn = 1'b0;
    cyc(3);
    rstn = 1'b1;
    cyc(3);
    acc(0, 5'h01, 5'h12, 16'h0000, 16'h00e1, 1);
    k = 0;
    while (expq.size() != 0 && k < 20) begin
      cyc(1);
      k = k + 1;
    end
    if (expq.size() != 0)
      miscompares = miscompares + 1;
    conclude;
  end
endmodule // tb_phy_mode_mdix_irq_regs
